/* verilog/accel_pin_power_control.sv */
// Accelerometer pin routing, self-test, power control and soft-reset register group.
`timescale 1ns/100ps
module accel_pin_power_control
  import accel_ctrl_pkg::*;
#(
  parameter int SOFT_RESET_WAIT = SOFT_RESET_CYCLES,
  parameter logic [15:0] SELF_TEST_OFFSET = 16'h0400
)
(
  input wire logic clk,
  input wire logic sys_rst,
  // Register port: one-cycle strobes in, registered read answer out.
  input reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Event sources and the raw sample stream from the acquisition path.
  input wire logic data_ready_evt,
  input wire logic fifo_full_evt,
  input wire logic [12:0] fifo_fill_bytes,
  input wire logic [12:0] fifo_watermark_level,
  input wire logic [15:0] raw_sample,
  input wire logic raw_sample_valid,
  // Conditioned samples and status.
  output logic [15:0] sample_out,
  output logic sample_valid,
  output logic acquire_en,
  output logic soft_reset_busy,
  // Interrupt pins; the second one can also be read back as an input.
  output logic first_irq_pin,
  input wire logic second_irq_pin_i,
  output logic second_irq_pin_o,
  output logic second_irq_pin_oe,
  output logic second_pin_input_level
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // OR of the events whose routing bits are set; shared by both pins.
  // Route bits are ordered data ready, watermark, full, as in the register.
  function automatic logic routed_any(input logic [2:0] route, input irq_evt_t ev);
    routed_any = (route[2] & ev.data_ready) | (route[1] & ev.fifo_watermark)
               | (route[0] & ev.fifo_full);
  endfunction

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  // Stored configuration bytes and the soft-reset sequencer state.
  logic [7:0] pin2_conf_r;
  logic [7:0] routing_r;
  logic [7:0] self_test_r;
  logic [7:0] pwr_save_r;
  logic [7:0] pwr_en_r;
  soft_rst_state_t sr_state_r;
  soft_rst_state_t sr_state_nxt;
  logic [SOFT_CNT_W-1:0] sr_cnt_r;
  logic [SOFT_CNT_W-1:0] sr_cnt_nxt;

  // Address decode of a write strobe.
  wire logic wr_pin2 = reg_req.wr && (reg_req.addr == ADDR_PIN2_CONF);
  wire logic wr_routing = reg_req.wr && (reg_req.addr == ADDR_ROUTING);
  wire logic wr_self_test = reg_req.wr && (reg_req.addr == ADDR_SELF_TEST);
  wire logic wr_pwr_save = reg_req.wr && (reg_req.addr == ADDR_PWR_SAVE);
  wire logic wr_pwr_en = reg_req.wr && (reg_req.addr == ADDR_PWR_EN);
  wire logic wr_soft_rst = reg_req.wr && (reg_req.addr == ADDR_SOFT_RST);

  // Only the exact command code starts a reset; other values are dropped.
  // Nothing of the written byte is kept, so the register has no state.
  wire logic soft_cmd = wr_soft_rst && (reg_req.wdata == SOFT_RST_CMD);

  // ----------------------------------------------------------------------
  // Soft-reset sequencer
  // ----------------------------------------------------------------------

  // The sequence does not look at the power registers, so suspend
  // cannot block it. A repeated command during the wait is ignored.
  // The counter starts at zero on the edge after the command, so the
  // restore lands on the edge that ends the last cycle of the wait and
  // busy covers exactly SOFT_RESET_WAIT cycles.
  wire logic sr_last = (sr_cnt_r == SOFT_CNT_W'(SOFT_RESET_WAIT - 1));
  wire logic sr_restore = (sr_state_r == SR_WAIT) && sr_last;

  // Next state: idle waits for the command, wait counts to its end.
  // The default branch pulls an illegal state back to idle.
  always_comb begin
    sr_state_nxt = sr_state_r;
    sr_cnt_nxt = sr_cnt_r;
    case (sr_state_r)
      SR_IDLE: begin
        sr_cnt_nxt = '0;
        if (soft_cmd) begin
          sr_state_nxt = SR_WAIT;
        end
      end
      SR_WAIT: begin
        sr_cnt_nxt = sr_cnt_r + SOFT_CNT_W'(1);
        if (sr_last) begin
          sr_state_nxt = SR_IDLE;
          sr_cnt_nxt = '0;
        end
      end
      default: begin
        sr_state_nxt = SR_IDLE;
        sr_cnt_nxt = '0;
      end
    endcase
  end

  // Sequencer state.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sr_state_r <= SR_IDLE;
      sr_cnt_r <= '0;
    end else begin
      sr_state_r <= sr_state_nxt;
      sr_cnt_r <= sr_cnt_nxt;
    end
  end

  assign soft_reset_busy = (sr_state_r == SR_WAIT);

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------

  // Restore beats a host write landing in the same cycle, since the
  // command promises every setting returns to its reset value. Each
  // register has its own short process; a write strobe only touches
  // the register that its address selects.

  // Second pin configuration: only the documented bits are stored.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin2_conf_r <= PIN2_CONF_RST;
    end else if (sr_restore) begin
      pin2_conf_r <= PIN2_CONF_RST;
    end else if (wr_pin2) begin
      pin2_conf_r <= reg_req.wdata & PIN2_CONF_MASK;
    end
  end

  // Event routing: the two reserved bits are never stored.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      routing_r <= ROUTING_RST;
    end else if (sr_restore) begin
      routing_r <= ROUTING_RST;
    end else if (wr_routing) begin
      routing_r <= reg_req.wdata & ROUTING_MASK;
    end
  end

  // Self-test code: kept until the host writes another code or a soft reset restores the off code.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      self_test_r <= ST_OFF;
    end else if (sr_restore) begin
      self_test_r <= ST_OFF;
    end else if (wr_self_test) begin
      self_test_r <= reg_req.wdata;
    end
  end

  // Power-save code: the full byte is kept; only the active code wakes it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_save_r <= PWR_SUSPEND;
    end else if (sr_restore) begin
      pwr_save_r <= PWR_SUSPEND;
    end else if (wr_pwr_save) begin
      pwr_save_r <= reg_req.wdata;
    end
  end

  // Enable code: the full byte is kept; only the on code switches on.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_en_r <= EN_OFF;
    end else if (sr_restore) begin
      pwr_en_r <= EN_OFF;
    end else if (wr_pwr_en) begin
      pwr_en_r <= reg_req.wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------

  // Reserved bits read zero because they are never stored.
  // A read in the same cycle as a write returns the value before it.
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_req.addr)
      ADDR_PIN2_CONF: rd_mux = pin2_conf_r;
      ADDR_ROUTING: rd_mux = routing_r;
      ADDR_SELF_TEST: rd_mux = self_test_r;
      ADDR_PWR_SAVE: rd_mux = pwr_save_r;
      ADDR_PWR_EN: rd_mux = pwr_en_r;
      ADDR_SOFT_RST: rd_mux = READ_ZERO;
      default: rd_mux = READ_ZERO;
    endcase
  end

  // Read data is registered one cycle after the strobe.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= READ_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Power and self-test decode
  // ----------------------------------------------------------------------

  // Only the exact codes count; anything else keeps the safe state.
  // Acquisition also stops during the soft-reset wait; the registered acquire_en falls one cycle after busy rises.
  wire logic mode_active = (pwr_save_r == PWR_ACTIVE);
  wire logic accel_on = (pwr_en_r == EN_ON);
  wire logic st_pos = (self_test_r == ST_POS);
  wire logic st_neg = (self_test_r == ST_NEG);
  wire logic acquire_nxt = mode_active && accel_on && !soft_reset_busy;

  // Steady offset, not a pulse: it holds as long as the code stays.
  // The sum wraps at 16 bits; no saturation is applied near full scale.
  wire logic [15:0] st_offset = st_pos ? SELF_TEST_OFFSET
                              : (st_neg ? (16'h0000 - SELF_TEST_OFFSET) : 16'h0000);
  wire logic [15:0] sample_nxt = raw_sample + st_offset;

  // Sample path: nothing is captured while suspended or switched off.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acquire_en <= 1'b0;
      sample_valid <= 1'b0;
      sample_out <= 16'h0000;
    end else begin
      acquire_en <= acquire_nxt;
      sample_valid <= acquire_nxt && raw_sample_valid;
      if (acquire_nxt && raw_sample_valid) begin
        sample_out <= sample_nxt;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt routing
  // ----------------------------------------------------------------------
  // Event sources gathered in one word; the watermark compare works on
  // bytes, and a level of zero keeps that event permanently active.
  irq_evt_t events;
  assign events.data_ready = data_ready_evt;
  assign events.fifo_watermark = (fifo_fill_bytes >= fifo_watermark_level);
  assign events.fifo_full = fifo_full_evt;

  // Each pin shows the OR of its routed events; the shared function keeps
  // the two decodes identical.
  wire logic pin1_active = routed_any(routing_r[ROUTE1_BASE +: 3], events);
  wire logic pin2_active = routed_any(routing_r[ROUTE2_BASE +: 3], events);

  // The first pin's own configuration lives elsewhere; it is driven
  // here as a plain active-high level.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_irq_pin <= 1'b0;
    end else begin
      first_irq_pin <= pin1_active;
    end
  end

  // Output stage settings of the second pin, taken from its register.
  pin_cfg_t pin2_cfg;
  assign pin2_cfg.output_en = pin2_conf_r[PIN2_OUT_BIT];
  assign pin2_cfg.drive_sel = pin2_conf_r[PIN2_OD_BIT];
  assign pin2_cfg.polarity = pin2_conf_r[PIN2_LVL_BIT];

  // The stage registers level and enable together, so the pin never
  // drives a half-updated value.
  irq_pin_driver u_pin2 (
    .clk(clk),
    .sys_rst(sys_rst),
    .active(pin2_active),
    .cfg(pin2_cfg),
    .pin_o(second_irq_pin_o),
    .pin_oe(second_irq_pin_oe)
  );

  // Input use of the second pin: level passed on only when enabled.
  // The pin is taken as synchronous to the clock, so no extra flops
  // are spent on it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      second_pin_input_level <= 1'b0;
    end else begin
      second_pin_input_level <= pin2_conf_r[PIN2_IN_BIT] & second_irq_pin_i;
    end
  end

endmodule

/* include/accel_ctrl_pkg.sv */
// Constants, field layout and carrier types for the accelerometer pin and power controls.
package accel_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_PIN2_CONF = 8'h54;
  localparam logic [7:0] ADDR_ROUTING = 8'h58;
  localparam logic [7:0] ADDR_SELF_TEST = 8'h6D;
  localparam logic [7:0] ADDR_PWR_SAVE = 8'h7C;
  localparam logic [7:0] ADDR_PWR_EN = 8'h7D;
  localparam logic [7:0] ADDR_SOFT_RST = 8'h7E;

  // ----------------------------------------------------------------------
  // Field positions and writable masks
  // ----------------------------------------------------------------------
  localparam int PIN2_IN_BIT = 4;
  localparam int PIN2_OUT_BIT = 3;
  localparam int PIN2_OD_BIT = 2;
  localparam int PIN2_LVL_BIT = 1;
  localparam int ROUTE2_BASE = 4;
  localparam int ROUTE1_BASE = 0;
  localparam logic [7:0] PIN2_CONF_MASK = 8'h1E;
  localparam logic [7:0] ROUTING_MASK = 8'h77;

  // ----------------------------------------------------------------------
  // Reset values and command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] PIN2_CONF_RST = 8'h00;
  localparam logic [7:0] ROUTING_RST = 8'h00;
  localparam logic [7:0] ST_OFF = 8'h00;
  localparam logic [7:0] ST_POS = 8'h0D;
  localparam logic [7:0] ST_NEG = 8'h09;
  localparam logic [7:0] PWR_SUSPEND = 8'h03;
  localparam logic [7:0] PWR_ACTIVE = 8'h00;
  localparam logic [7:0] EN_OFF = 8'h00;
  localparam logic [7:0] EN_ON = 8'h04;
  localparam logic [7:0] SOFT_RST_CMD = 8'hB6;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 20000;
  localparam int SOFT_RESET_TIME_US = 1000;
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam int SOFT_CNT_W = 16;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic data_ready;
    logic fifo_watermark;
    logic fifo_full;
  } irq_evt_t;

  typedef struct packed {
    logic output_en;
    logic drive_sel;
    logic polarity;
  } pin_cfg_t;

  typedef enum logic [0:0] {
    SR_IDLE,
    SR_WAIT
  } soft_rst_state_t;

endpackage

/* verilog/irq_pin_driver.sv */
// Output stage of one interrupt pin: polarity, push-pull or open-drain, registered.
`timescale 1ns/100ps
module irq_pin_driver
  import accel_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic active,
  input pin_cfg_t cfg,
  output logic pin_o,
  output logic pin_oe
);

  // Electrical level and enable for the wanted logical state.
  // Open-drain only pulls while active, so the line floats back when idle.
  wire logic level_nxt = cfg.polarity ? active : ~active;
  wire logic od_drive = cfg.polarity ? 1'b1 : 1'b0;
  wire logic pin_o_nxt = cfg.drive_sel ? od_drive : level_nxt;
  wire logic pin_oe_nxt = cfg.output_en & (~cfg.drive_sel | active);

  // Registered so the pin never shows decode glitches.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_o <= pin_o_nxt;
      pin_oe <= pin_oe_nxt;
    end
  end

endmodule

/* sim/accel_pin_power_control_sva.sv */
// Concurrent checks on the ports of the accelerometer pin and power block.
`timescale 1ns/100ps
module accel_ppc_chk
  import accel_ctrl_pkg::*;
#(parameter int SOFT_RESET_WAIT = 8)
(
  input wire logic clk,
  input wire logic sys_rst,
  input reg_req_t reg_req,
  input logic [7:0] reg_rdata,
  input logic reg_rvalid,
  input wire logic data_ready_evt,
  input wire logic fifo_full_evt,
  input wire logic [12:0] fifo_fill_bytes,
  input wire logic [12:0] fifo_watermark_level,
  input wire logic raw_sample_valid,
  input logic sample_valid,
  input logic acquire_en,
  input logic soft_reset_busy,
  input logic first_irq_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [15:0] busy_cnt_r;
  wire cmd_w = reg_req.wr && reg_req.addr == ADDR_SOFT_RST && reg_req.wdata == SOFT_RST_CMD;
  // Counts busy cycles, so the wait length is checked without a long repetition.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) busy_cnt_r <= 16'h0000;
    else busy_cnt_r <= soft_reset_busy ? busy_cnt_r + 16'h0001 : 16'h0000;
  end
  rd_answer_a: assert property (reg_req.rd |=> reg_rvalid)
    else $error("read answer missing");
  rst_read_a: assert property (reg_req.rd && reg_req.addr == ADDR_SOFT_RST
    |=> reg_rdata == READ_ZERO)
    else $error("soft reset register read not zero");
  busy_start_a: assert property (cmd_w && !soft_reset_busy |=> soft_reset_busy)
    else $error("reset command not accepted");
  busy_len_a: assert property ($fell(soft_reset_busy)
    |-> busy_cnt_r == SOFT_RESET_WAIT)
    else $error("reset wait has wrong length");
  restore_pin_a: assert property ($fell(soft_reset_busy) |=> !first_irq_pin)
    else $error("routing not restored");
  acquire_off_a: assert property (soft_reset_busy && $past(soft_reset_busy)
    |-> !acquire_en)
    else $error("acquiring during reset wait");
  sample_gate_a: assert property (sample_valid |-> acquire_en && $past(raw_sample_valid))
    else $error("sample passed while halted");
  pin_idle_a: assert property (!data_ready_evt && !fifo_full_evt &&
    fifo_fill_bytes < fifo_watermark_level |=> !first_irq_pin)
    else $error("first pin active without event");
  cover property (cmd_w ##1 soft_reset_busy);
  cover property (sample_valid);
  cover property (first_irq_pin);
endmodule

bind accel_pin_power_control accel_ppc_chk #(.SOFT_RESET_WAIT(SOFT_RESET_WAIT)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .data_ready_evt(data_ready_evt), .fifo_full_evt(fifo_full_evt),
  .fifo_fill_bytes(fifo_fill_bytes), .fifo_watermark_level(fifo_watermark_level),
  .raw_sample_valid(raw_sample_valid), .sample_valid(sample_valid), .acquire_en(acquire_en),
  .soft_reset_busy(soft_reset_busy), .first_irq_pin(first_irq_pin));

/* sim/host_model.sv */
// Host processor model issuing single-byte register requests.
`timescale 1ns/100ps
module host_model
  import accel_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output reg_req_t reg_req
);
  // Idle until the first call; each strobe lives for exactly one edge.
  initial reg_req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    reg_req <= '0;
  endtask
  // The answer is registered at the taking edge itself, so it is sampled 1 ns after that edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    reg_req <= '0;
    #1;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule

/* sim/accel_pin_power_control_tb.sv */
// Self-checking testbench for the accelerometer pin and power block.
`timescale 1ns/100ps
module accel_pin_power_control_tb
  import accel_ctrl_pkg::*;
;
  localparam int WAIT_N = 8;
  localparam logic [15:0] OFS = 16'h0123;
  localparam logic [12:0] WM = 13'h0100;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  reg_req_t reg_req;
  logic [7:0] reg_rdata, rd_v;
  logic reg_rvalid, rv_v, sample_valid, acquire_en, busy, pin1, pin2_o, pin2_oe, in_lvl, e_oe;
  logic drdy = 1'b0, ffull = 1'b0, ext_lvl = 1'b1, raw_v = 1'b0;
  logic [12:0] fill = 13'h0000;
  logic [15:0] raw = 16'h0000, s_out;
  logic [7:0] ra[7] = '{ADDR_PIN2_CONF, ADDR_ROUTING, ADDR_SELF_TEST, ADDR_PWR_SAVE,
    ADDR_PWR_EN, ADDR_SOFT_RST, 8'h55};
  logic [7:0] r0[7] = '{PIN2_CONF_RST, ROUTING_RST, ST_OFF, PWR_SUSPEND, EN_OFF,
    READ_ZERO, READ_ZERO};
  logic [7:0] pc[5] = '{8'h08, 8'h0C, 8'h0E, 8'h0A, 8'h00};
  logic [7:0] st[4] = '{ST_POS, ST_NEG, 8'h05, ST_OFF};
  logic [15:0] so[4] = '{OFS, -OFS, 16'h0000, 16'h0000};
  int n_mismatch = 0;
  int checks_done = 0;
  int n;
  // The second pin wire follows the board level ext_lvl, high at first and driven low later, when nobody drives it.
  wire pin2_in = pin2_oe ? pin2_o : ext_lvl;
  always #25 clk = ~clk;

  accel_pin_power_control #(.SOFT_RESET_WAIT(WAIT_N), .SELF_TEST_OFFSET(OFS))
  u_accel_pin_power_control (
    .clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .data_ready_evt(drdy), .fifo_full_evt(ffull),
    .fifo_fill_bytes(fill), .fifo_watermark_level(WM), .raw_sample(raw),
    .raw_sample_valid(raw_v), .sample_out(s_out), .sample_valid(sample_valid),
    .acquire_en(acquire_en), .soft_reset_busy(busy), .first_irq_pin(pin1),
    .second_irq_pin_i(pin2_in), .second_irq_pin_o(pin2_o), .second_irq_pin_oe(pin2_oe),
    .second_pin_input_level(in_lvl));
  host_model u_host_model (.clk(clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_req(reg_req));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_host_model.rd(a, rd_v, rv_v);
    chk({7'h00, rv_v, rd_v}, {7'h00, 1'h1, e});
  endtask
  // Events as {data ready, watermark, full}; the pins lag by one flop.
  task automatic ev(input logic [2:0] e);
    @(posedge clk);
    drdy <= e[2];
    fill <= e[1] ? WM : WM - 13'h0001;
    ffull <= e[0];
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic smp(input logic [15:0] v, input logic ok, input logic [15:0] e);
    @(posedge clk);
    raw <= v;
    raw_v <= 1'b1;
    @(posedge clk);
    raw_v <= 1'b0;
    #1;
    chk(16'(sample_valid), 16'(ok));
    if (ok) chk(s_out, e);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (ra[i]) rchk(ra[i], r0[i]);
    u_host_model.wr(ADDR_PIN2_CONF, 8'hFF);
    rchk(ADDR_PIN2_CONF, 8'h1E);
    u_host_model.wr(ADDR_ROUTING, 8'hFF);
    rchk(ADDR_ROUTING, 8'h77);
    $display("test reset and masks done");
    u_host_model.wr(ADDR_PIN2_CONF, 8'h0A);
    for (int i = 0; i < 6; i++) begin
      u_host_model.wr(ADDR_ROUTING, 8'h01 << (i < 3 ? i : i + 1));
      ev(~(3'h1 << (i % 3)));
      chk(16'({pin1, pin2_o}), 16'h0000);
      ev(3'h1 << (i % 3));
      chk(16'({pin1, pin2_o}), 16'(i < 3 ? 2 : 1));
    end
    $display("test routing done");
    u_host_model.wr(ADDR_ROUTING, 8'h40);
    foreach (pc[i]) begin
      u_host_model.wr(ADDR_PIN2_CONF, pc[i]);
      for (int a = 0; a < 2; a++) begin
        ev(a == 1 ? 3'h4 : 3'h0);
        e_oe = pc[i][3] && (!pc[i][2] || a == 1);
        chk(16'({pin2_oe, pin2_oe & pin2_o}),
          16'({e_oe, e_oe & (a == 1 ? pc[i][1] : !pc[i][1])}));
      end
    end
    chk(16'(in_lvl), 16'h0000);
    u_host_model.wr(ADDR_PIN2_CONF, 8'h10);
    ev(3'h0);
    chk(16'(in_lvl), 16'h0001);
    @(posedge clk);
    ext_lvl <= 1'b0;
    ev(3'h0);
    chk(16'(in_lvl), 16'h0000);
    $display("test pin drive done");
    u_host_model.wr(ADDR_PWR_SAVE, PWR_ACTIVE);
    u_host_model.wr(ADDR_PWR_EN, EN_ON);
    ev(3'h0);
    chk(16'(acquire_en), 16'h0001);
    foreach (st[i]) begin
      u_host_model.wr(ADDR_SELF_TEST, st[i]);
      smp(16'h1234, 1'b1, 16'h1234 + so[i]);
      smp(16'hFFF0, 1'b1, 16'hFFF0 + so[i]);
    end
    u_host_model.wr(ADDR_PWR_SAVE, PWR_SUSPEND);
    ev(3'h0);
    chk(16'(acquire_en), 16'h0000);
    smp(16'h1234, 1'b0, 16'h0000);
    $display("test samples done");
    u_host_model.wr(ADDR_SOFT_RST, 8'h55);
    ev(3'h0);
    chk(16'(busy), 16'h0000);
    rchk(ADDR_PWR_EN, EN_ON);
    for (int k = 0; k < 2; k++) begin
      u_host_model.wr(ADDR_PWR_SAVE, k == 1 ? PWR_ACTIVE : PWR_SUSPEND);
      u_host_model.wr(ADDR_PWR_EN, EN_ON);
      u_host_model.wr(ADDR_ROUTING, 8'h07);
      ev(3'h1);
      u_host_model.wr(ADDR_SOFT_RST, SOFT_RST_CMD);
      #1;
      chk(16'(busy), 16'h0001);
      n = 0;
      while (busy && n < 40) begin
        @(posedge clk);
        #1;
        n++;
      end
      if (n == 40) begin
        n_mismatch++;
        final_report();
      end
      chk(16'(n), 16'(WAIT_N));
      foreach (ra[i]) rchk(ra[i], r0[i]);
      chk(16'(pin1), 16'h0000);
    end
    $display("test soft reset done");
    final_report();
  end
endmodule
